/* rtl/fast_adc_capture.sv */
`timescale 1ns/1ps
`default_nettype none

module fast_adc_capture
	import fast_adc_capture_pkg::*;
#(
	parameter int SPI_HALF = SPI_HALF_CYC
)
(
	// Clock and reset
	input  wire logic             sys_clk_in,
	input  wire logic             arst_n_in,
	// On-chip bus
	input  wire bus_req_s         bus_in,
	output logic                  bus_ack_out,
	output logic [31:0]           bus_rdata_out,
	// Converter pins
	input  wire logic             adc_clk_in,
	input  wire logic [ADC_W-1:0] adc_data_in,
	output logic                  adc_clk_out,
	output logic                  adc_pd_out,
	output logic                  adc_rst_out,
	// Trigger pins
	input  wire logic [1:0]       trig_in,
	// Sample memory
	output mem_wr_s               mem_out,
	// SPI configuration port
	output logic                  spi_sclk_out,
	output logic                  spi_mosi_out,
	output logic [3:0]            spi_cs_n_out
);

	function automatic logic [3:0] onehot4(input logic [1:0] sel);
		onehot4 = 4'h1 << sel;
	endfunction

	cap_state_e       cap_q;
	spi_state_e       spi_q;
	logic             ack_q;
	logic [27:0]      start_q;
	logic [27:0]      end_q;
	logic [7:0]       conv_q;
	logic [4:0]       trig_q;
	logic             fired_q;
	logic [27:0]      wr_addr_q;
	logic [1:0]       pend_q;
	logic [2:0]       aclk_q;
	logic [ADC_W-1:0] d1_q;
	logic [ADC_W-1:0] d2_q;
	logic [ADC_W-1:0] rise_word_q;
	logic [ADC_W-1:0] first_q;
	logic [ADC_W-1:0] second_q;
	logic [1:0]       phase_q;
	logic [1:0]       tr1_q;
	logic [1:0]       tr2_q;
	logic             tsel_prev_q;
	logic             ddr_phase_q;
	logic [15:0]      sh_q;
	logic [4:0]       bits_q;
	logic [7:0]       half_q;
	logic             sclk_q;
	logic             cs_act_q;
	logic [1:0]       cs_sel_q;
	logic             release_q;

	logic             req;
	logic             spi_hit;
	logic             cap_hit;
	logic             spi_stall;
	logic             take;
	logic             cap_wr;
	logic             wr_trig;
	logic             halt_req;
	logic             launch_req;
	logic             tsel;
	logic             trig_edge;
	logic             trig_fire;
	logic             word_wr;
	logic             at_end;
	logic             spi_tick;

	// Address decode
	assign req       = bus_in.wr | bus_in.rd;
	assign spi_hit   = bus_in.addr[15:12] == SPI_BASE[15:12];
	assign cap_hit   = bus_in.addr[15:4] == CAP_BASE[15:4];
	// A write to the bridge waits while the previous byte is still shifting
	assign spi_stall = spi_hit & bus_in.wr & (spi_q != SPI_IDLE);
	assign take      = req & ~ack_q & ~spi_stall;
	assign cap_wr    = take & bus_in.wr & cap_hit;
	assign wr_trig   = cap_wr & (bus_in.addr[3:0] == OFS_TRIG_CTL);
	assign halt_req  = wr_trig & bus_in.wdata[HALT_BIT];
	assign launch_req = wr_trig & bus_in.wdata[LAUNCH_BIT] & ~bus_in.wdata[HALT_BIT];

	assign bus_ack_out = ack_q;

	always_ff @(posedge sys_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			ack_q <= 1'b0;
		else
			ack_q <= take;
	end

	// Read path; the board region and unmapped addresses answer zero
	always_ff @(posedge sys_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			bus_rdata_out <= 32'h0000_0000;
		else if (take && bus_in.rd)
		begin
			bus_rdata_out <= 32'h0000_0000;
			if (cap_hit)
			begin
				unique case (bus_in.addr[3:0])
					OFS_START_TOP: bus_rdata_out[3:0] <= start_q[27:24];
					OFS_START_B2:  bus_rdata_out[7:0] <= start_q[23:16];
					OFS_START_B1:  bus_rdata_out[7:0] <= start_q[15:8];
					OFS_START_B0:  bus_rdata_out[7:0] <= start_q[7:0];
					OFS_END_TOP:   bus_rdata_out[3:0] <= end_q[27:24];
					OFS_END_B2:    bus_rdata_out[7:0] <= end_q[23:16];
					OFS_END_B1:    bus_rdata_out[7:0] <= end_q[15:8];
					OFS_END_B0:    bus_rdata_out[7:0] <= end_q[7:0];
					OFS_CONV_CTL:  bus_rdata_out[7:0] <= conv_q;
					OFS_TRIG_CTL:  bus_rdata_out[7:0] <= {cap_q == CAP_RUN, fired_q, 1'b0, trig_q};
					default:       bus_rdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Register writes
	always_ff @(posedge sys_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			start_q <= ADDR_RST;
			end_q   <= ADDR_RST;
			conv_q  <= CTL_RST;
			trig_q  <= CTL_RST[4:0];
		end
		else if (cap_wr)
		begin
			unique case (bus_in.addr[3:0])
				OFS_START_TOP: start_q[27:24] <= bus_in.wdata[3:0];
				OFS_START_B2:  start_q[23:16] <= bus_in.wdata[7:0];
				OFS_START_B1:  start_q[15:8]  <= bus_in.wdata[7:0];
				OFS_START_B0:  start_q[7:0]   <= bus_in.wdata[7:0];
				OFS_END_TOP:   end_q[27:24]   <= bus_in.wdata[3:0];
				OFS_END_B2:    end_q[23:16]   <= bus_in.wdata[7:0];
				OFS_END_B1:    end_q[15:8]    <= bus_in.wdata[7:0];
				OFS_END_B0:    end_q[7:0]     <= bus_in.wdata[7:0];
				OFS_CONV_CTL:  conv_q         <= bus_in.wdata[7:0];
				OFS_TRIG_CTL:  trig_q         <= bus_in.wdata[4:0];
				default:       conv_q         <= conv_q;
			endcase
		end
	end

	// Converter pins
	assign adc_pd_out  = ~conv_q[SLEEP_BIT];
	assign adc_rst_out = ~conv_q[CRESET_BIT];

	// Two-level output cell emulated at half the system rate
	always_ff @(posedge sys_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ddr_phase_q <= 1'b0;
			adc_clk_out <= 1'b0;
		end
		else
		begin
			ddr_phase_q <= ~ddr_phase_q;
			adc_clk_out <= ddr_phase_q ? conv_q[CLK0_BIT] : conv_q[CLK1_BIT];
		end
	end

	// Pin synchronisers; the second stage feeds logic, and the third too for the link clock
	always_ff @(posedge sys_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			aclk_q <= 3'h0;
			d1_q   <= '0;
			d2_q   <= '0;
			tr1_q  <= 2'h0;
			tr2_q  <= 2'h0;
		end
		else
		begin
			aclk_q <= {aclk_q[1:0], adc_clk_in};
			d1_q   <= adc_data_in;
			d2_q   <= d1_q;
			tr1_q  <= trig_in;
			tr2_q  <= tr1_q;
		end
	end

	// Trigger selection and edge detection
	assign tsel      = tr2_q[trig_q[TCH_BIT]];
	assign trig_edge = tsel & ~tsel_prev_q;
	assign trig_fire = trig_edge & trig_q[LISTEN_BIT] & (cap_q == CAP_IDLE)
		& ~(trig_q[SINGLE_BIT] & fired_q) & ~wr_trig;

	always_ff @(posedge sys_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			tsel_prev_q <= 1'b0;
			fired_q     <= 1'b0;
		end
		else
		begin
			tsel_prev_q <= tsel;
			if (trig_fire)
				fired_q <= 1'b1;
			else if (wr_trig)
				fired_q <= 1'b0;
		end
	end

	// DDR word capture; a pair completes on the falling edge of the link clock
	always_ff @(posedge sys_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rise_word_q <= '0;
			first_q     <= '0;
			second_q    <= '0;
			phase_q     <= 2'h0;
			pend_q      <= 2'h0;
		end
		else if (aclk_q[2] && !aclk_q[1])
		begin
			// Slow link clock leaves eight cycles per pair, so no overrun
			first_q  <= conv_q[ORDER_BIT] ? d2_q : rise_word_q;
			second_q <= conv_q[ORDER_BIT] ? rise_word_q : d2_q;
			phase_q  <= {aclk_q[2], aclk_q[1]};
			pend_q   <= 2'h2;
		end
		else
		begin
			if (aclk_q[1] && !aclk_q[2])
				rise_word_q <= d2_q;
			if (pend_q != 2'h0)
				pend_q <= pend_q - 2'h1;
		end
	end

	assign word_wr = (cap_q == CAP_RUN) & (pend_q != 2'h0);
	assign at_end  = wr_addr_q == end_q;

	// Capture run control
	always_ff @(posedge sys_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			cap_q     <= CAP_IDLE;
			wr_addr_q <= ADDR_RST;
		end
		else if (halt_req)
			cap_q <= CAP_IDLE;
		else if (launch_req || trig_fire)
		begin
			cap_q     <= CAP_RUN;
			wr_addr_q <= start_q;
		end
		else if (word_wr)
		begin
			if (!at_end)
				wr_addr_q <= wr_addr_q + 28'h000_0001;
			else if (trig_q[LAUNCH_BIT])
				wr_addr_q <= start_q;
			else
				cap_q <= CAP_IDLE;
		end
	end

	// Memory word: tags on top, optional phase bits directly above the sample
	always_ff @(posedge sys_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			mem_out <= '0;
		else
		begin
			mem_out.valid <= word_wr;
			mem_out.addr  <= wr_addr_q;
			mem_out.data  <= {conv_q[TAGU_BIT], conv_q[TAGL_BIT],
				conv_q[PHASE_BIT] ? phase_q : 2'h0,
				(pend_q == 2'h2) ? first_q : second_q};
		end
	end

	// SPI bridge
	assign spi_tick     = half_q == 8'(SPI_HALF - 1);
	assign spi_sclk_out = sclk_q;
	assign spi_mosi_out = sh_q[15];
	assign spi_cs_n_out = ~(cs_act_q ? onehot4(cs_sel_q) : 4'h0);

	always_ff @(posedge sys_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			spi_q     <= SPI_IDLE;
			sh_q      <= 16'h0000;
			bits_q    <= 5'h00;
			half_q    <= 8'h00;
			sclk_q    <= 1'b0;
			cs_act_q  <= 1'b0;
			cs_sel_q  <= 2'h0;
			release_q <= 1'b0;
		end
		else
		begin
			unique case (spi_q)
				SPI_IDLE:
				begin
					half_q <= 8'h00;
					if (take && bus_in.wr && spi_hit)
					begin
						spi_q     <= SPI_SHIFT;
						cs_act_q  <= 1'b1;
						cs_sel_q  <= bus_in.addr[SPI_SEL_LSB +: 2];
						release_q <= bus_in.addr[SPI_END_BIT];
						if (bus_in.addr[SPI_USE_BIT])
						begin
							sh_q   <= {bus_in.addr[7:0], bus_in.wdata[7:0]};
							bits_q <= 5'h10;
						end
						else
						begin
							sh_q   <= {bus_in.wdata[7:0], 8'h00};
							bits_q <= 5'h08;
						end
					end
				end
				SPI_SHIFT:
				begin
					half_q <= spi_tick ? 8'h00 : half_q + 8'h01;
					if (spi_tick)
					begin
						sclk_q <= ~sclk_q;
						if (sclk_q)
						begin
							sh_q   <= {sh_q[14:0], 1'b0};
							bits_q <= bits_q - 5'h01;
							if (bits_q == 5'h01)
							begin
								spi_q <= SPI_IDLE;
								// Chained writes keep select low between bytes
								if (release_q)
									cs_act_q <= 1'b0;
							end
						end
					end
				end
			endcase
		end
	end

	// Checks
	a_pd_inverse: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		adc_pd_out != conv_q[SLEEP_BIT]) else $error("power-down pin not inverted");

	a_rst_inverse: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		adc_rst_out == !conv_q[CRESET_BIT]) else $error("reset pin not inverted");

	a_launch_starts: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		launch_req |=> cap_q == CAP_RUN && wr_addr_q == $past(start_q))
		else $error("launch did not start run at start address");

	a_halt_stops: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		halt_req |=> cap_q == CAP_IDLE ##1 !mem_out.valid)
		else $error("halt did not stop run");

	a_end_stops: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		word_wr && at_end && !trig_q[LAUNCH_BIT] && !wr_trig |=> cap_q == CAP_IDLE)
		else $error("run passed end address");

	a_end_restart: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		word_wr && at_end && trig_q[LAUNCH_BIT] && !wr_trig
		|=> cap_q == CAP_RUN && wr_addr_q == $past(start_q))
		else $error("no restart at end address");

	a_addr_step: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		word_wr && !at_end && !wr_trig |=> wr_addr_q == $past(wr_addr_q) + 28'h000_0001)
		else $error("write address did not advance by one");

	a_tag_bits: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		mem_out.valid |-> mem_out.data[MEM_W-1] == $past(conv_q[TAGU_BIT])
			&& mem_out.data[MEM_W-2] == $past(conv_q[TAGL_BIT]))
		else $error("tag bits wrong in memory word");

	a_listen_gate: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		!trig_q[LISTEN_BIT] && cap_q == CAP_IDLE && !launch_req |=> cap_q == CAP_IDLE)
		else $error("run started while not listening");

	a_cs_held: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		spi_q == SPI_SHIFT |-> $countones(~spi_cs_n_out) == 1)
		else $error("select not held during transfer");

endmodule

`default_nettype wire

/* rtl/fast_adc_capture_pkg.sv */
package fast_adc_capture_pkg;

	// Bus region bases; SPI decoded on the top address nibble, capture on bits 15:4
	localparam logic [15:0] SPI_BASE      = 16'h1000;
	localparam logic [15:0] CAP_BASE      = 16'h3000;
	localparam logic [15:0] BOARD_BASE    = 16'h8000;

	// Capture register offsets, one register per address; byte-wide except the 4-bit OFS_START_TOP and OFS_END_TOP
	localparam logic [3:0]  OFS_START_TOP = 4'h0;
	localparam logic [3:0]  OFS_START_B2  = 4'h1;
	localparam logic [3:0]  OFS_START_B1  = 4'h2;
	localparam logic [3:0]  OFS_START_B0  = 4'h3;
	localparam logic [3:0]  OFS_END_TOP   = 4'h4;
	localparam logic [3:0]  OFS_END_B2    = 4'h5;
	localparam logic [3:0]  OFS_END_B1    = 4'h6;
	localparam logic [3:0]  OFS_END_B0    = 4'h7;
	localparam logic [3:0]  OFS_CONV_CTL  = 4'h8;
	localparam logic [3:0]  OFS_TRIG_CTL  = 4'h9;

	// converter_control fields
	localparam int SLEEP_BIT   = 7;
	localparam int CRESET_BIT  = 6;
	localparam int ORDER_BIT   = 5;
	localparam int PHASE_BIT   = 4;
	localparam int CLK1_BIT    = 3;
	localparam int CLK0_BIT    = 2;
	localparam int TAGU_BIT    = 1;
	localparam int TAGL_BIT    = 0;

	// trigger_and_run_control fields; 7 and 6 are read-only status
	localparam int BUSY_BIT    = 7;
	localparam int FIRED_BIT   = 6;
	localparam int TCH_BIT     = 4;
	localparam int LISTEN_BIT  = 3;
	localparam int SINGLE_BIT  = 2;
	localparam int HALT_BIT    = 1;
	localparam int LAUNCH_BIT  = 0;

	// SPI bridge address fields
	localparam int SPI_END_BIT = 11;
	localparam int SPI_USE_BIT = 10;
	localparam int SPI_SEL_LSB = 8;

	// Reset values
	localparam logic [7:0]  CTL_RST  = 8'h00;
	localparam logic [27:0] ADDR_RST = 28'h000_0000;

	// SPI clock half period in system clock cycles
	localparam int SPI_HALF_CYC = 2;

	// Sample and memory word geometry
	localparam int ADC_W  = 12;
	localparam int MEM_W  = 16;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} bus_req_s;

	typedef struct packed {
		logic             valid;
		logic [27:0]      addr;
		logic [MEM_W-1:0] data;
	} mem_wr_s;

	typedef enum logic [1:0] {
		CAP_IDLE = 2'b01,
		CAP_RUN  = 2'b10
	} cap_state_e;

	typedef enum logic [1:0] {
		SPI_IDLE  = 2'b01,
		SPI_SHIFT = 2'b10
	} spi_state_e;

endpackage

/* verif/adc_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_partner
	import fast_adc_capture_pkg::*;
(
	// Converter side
	output logic             lclk_out,
	output logic [ADC_W-1:0] sample_out,
	// SPI side
	input  wire logic        sclk_in,
	input  wire logic        mosi_in,
	input  wire logic [3:0]  cs_n_in,
	output logic [31:0]      shift_out,
	output logic [7:0]       nbits_out,
	output logic [3:0]       sel_out
);
	logic [7:0] cnt_q;
	// Converter clock runs free, as a real part fed by its oscillator
	initial
	begin
		cnt_q = 8'h00;
		forever
		begin
			lclk_out = 1'b1;
			sample_out = {4'h1, cnt_q};
			#400;
			lclk_out = 1'b0;
			sample_out = {4'h2, cnt_q};
			cnt_q = cnt_q + 8'h01;
			#400;
		end
	end
	// One process owns the capture: a select fall from all high clears it,
	// a rising clock shifts in one bit as a mode 0 slave does
	always @(negedge (&cs_n_in) or posedge sclk_in)
	begin
		if (sclk_in === 1'b1)
		begin
			if (cs_n_in != 4'hf)
			begin
				shift_out = {shift_out[30:0], mosi_in};
				nbits_out = nbits_out + 8'h01;
				sel_out = cs_n_in;
			end
		end
		else
		begin
			shift_out = 32'h0000_0000;
			nbits_out = 8'h00;
		end
	end
endmodule
`default_nettype wire

/* verif/fast_adc_capture_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fast_adc_capture_tb_top;
	import fast_adc_capture_pkg::*;
	logic             sys_clk_in;
	logic             arst_n_in;
	bus_req_s         bus_in;
	logic             bus_ack_out;
	logic [31:0]      bus_rdata_out;
	logic             adc_clk_in;
	logic [ADC_W-1:0] adc_data_in;
	logic             adc_clk_out;
	logic             adc_pd_out;
	logic             adc_rst_out;
	logic [1:0]       trig_in;
	mem_wr_s          mem_out;
	logic             spi_sclk_out;
	logic             spi_mosi_out;
	logic [3:0]       spi_cs_n_out;
	logic [31:0]      spi_shift;
	logic [7:0]       spi_nbits;
	logic [3:0]       spi_sel;
	logic [27:0]      q_addr[$];
	logic [15:0]      q_data[$];
	logic [31:0]      rd;
	logic             ca;
	int               error_cnt;
	int               n_compared;

	fast_adc_capture fast_adc_capture_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
		.bus_in(bus_in), .bus_ack_out(bus_ack_out), .bus_rdata_out(bus_rdata_out),
		.adc_clk_in(adc_clk_in), .adc_data_in(adc_data_in), .adc_clk_out(adc_clk_out),
		.adc_pd_out(adc_pd_out), .adc_rst_out(adc_rst_out), .trig_in(trig_in),
		.mem_out(mem_out), .spi_sclk_out(spi_sclk_out), .spi_mosi_out(spi_mosi_out),
		.spi_cs_n_out(spi_cs_n_out));
	adc_partner adc_partner_inst (.lclk_out(adc_clk_in), .sample_out(adc_data_in),
		.sclk_in(spi_sclk_out), .mosi_in(spi_mosi_out), .cs_n_in(spi_cs_n_out),
		.shift_out(spi_shift), .nbits_out(spi_nbits), .sel_out(spi_sel));

	initial
		sys_clk_in = 1'b0;
	always #50 sys_clk_in = ~sys_clk_in;

	always @(posedge sys_clk_in)
		if (mem_out.valid === 1'b1)
		begin
			q_addr.push_back(mem_out.addr);
			q_data.push_back(mem_out.data);
		end

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Request held until ack is sampled high at a rising edge
	task automatic bus_op(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		@(negedge sys_clk_in);
		bus_in = '{wr: w, rd: ~w, addr: a, wdata: d};
		n = 0;
		do
		begin
			@(posedge sys_clk_in);
			n++;
		end
		while (bus_ack_out !== 1'b1 && n < 300);
		rd = bus_rdata_out;
		if (n >= 300)
			error_cnt++;
		@(negedge sys_clk_in);
		bus_in = '0;
	endtask

	task automatic set_range(input logic [27:0] s, input logic [27:0] e);
		logic [63:0] v;
		v = {4'h0, s, 4'h0, e};
		for (int i = 0; i < 8; i++)
			bus_op(1'b1, CAP_BASE + 16'(i), {24'h00_0000, v[63-8*i -: 8]});
	endtask

	task automatic wait_words(input int k);
		int n;
		n = 0;
		while (q_addr.size() < k && n < 2000)
		begin
			@(posedge sys_clk_in);
			n++;
		end
		if (n >= 2000)
			error_cnt++;
	endtask

	task automatic check_words(input logic [27:0] s, input int k, input logic [1:0] tag,
		input logic [3:0] nib0);
		for (int i = 0; i < k; i++)
		begin
			check_val(32'(q_addr[i]), 32'(s + 28'(i % 4)));
			check_val(32'(q_data[i][15:14]), 32'(tag));
			check_val(32'(q_data[i][11:8]), 32'((i % 2) ? (nib0 ^ 4'h3) : nib0));
		end
	endtask

	task automatic check_busy(input logic b);
		bus_op(1'b0, 16'h3009, 32'h0000_0000);
		check_val(32'(rd[7]), 32'(b));
	endtask

	// Launch just after a link clock rise, so the run opens on a whole word pair
	task automatic launch_run;
		@(posedge adc_clk_in);
		#1;
		bus_op(1'b1, 16'h3009, 32'h0000_0001);
	endtask

	task automatic pulse(input int ch);
		@(negedge sys_clk_in);
		trig_in[ch] = 1'b1;
		repeat (3) @(negedge sys_clk_in);
		trig_in[ch] = 1'b0;
		repeat (3) @(negedge sys_clk_in);
	endtask

	task automatic t_regs;
		check_val(32'({adc_pd_out, adc_rst_out, spi_cs_n_out}), 32'h0000_003f);
		for (int i = 0; i < 10; i++)
		begin
			bus_op(1'b0, CAP_BASE + 16'(i), 32'h0000_0000);
			check_val(rd, 32'(CTL_RST));
		end
		bus_op(1'b1, 16'h3005, 32'h0000_00a5);
		bus_op(1'b1, 16'h8004, 32'h0000_0055);
		bus_op(1'b0, 16'h3005, 32'h0000_0000);
		check_val(rd, 32'h0000_00a5);
		bus_op(1'b0, 16'h8004, 32'h0000_0000);
		check_val(rd, 32'h0000_0000);
		bus_op(1'b0, 16'h3004, 32'h0000_0000);
		check_val(rd, 32'h0000_0000);
	endtask

	task automatic t_pins;
		bus_op(1'b1, 16'h3008, 32'h0000_00c0);
		check_val(32'({adc_pd_out, adc_rst_out}), 32'h0000_0000);
		bus_op(1'b1, 16'h3008, 32'h0000_0080);
		check_val(32'({adc_pd_out, adc_rst_out}), 32'h0000_0001);
		bus_op(1'b1, 16'h3008, 32'h0000_000c);
		ca = adc_clk_out;
		@(negedge sys_clk_in);
		check_val(32'({ca, adc_clk_out}), 32'h0000_0003);
		bus_op(1'b1, 16'h3008, 32'h0000_0008);
		ca = adc_clk_out;
		@(negedge sys_clk_in);
		check_val(32'(ca ^ adc_clk_out), 32'h0000_0001);
	endtask

	task automatic t_capture(input logic [7:0] ctl, input logic [1:0] tag, input logic [3:0] nib0,
		input logic ph);
		set_range(28'h510_0010, 28'h510_0013);
		bus_op(1'b1, 16'h3008, {24'h00_0000, ctl});
		q_addr.delete();
		q_data.delete();
		launch_run;
		bus_op(1'b1, 16'h3009, 32'h0000_0000);
		wait_words(4);
		// Long enough for a wrong restart to show extra words
		repeat (40) @(posedge sys_clk_in);
		check_val(32'(q_addr.size()), 32'h0000_0004);
		check_words(28'h510_0010, 4, tag, nib0);
		for (int i = 0; i < 4; i++)
			check_val(32'(q_data[i][13:12] != 2'b00), 32'(ph));
		check_busy(1'b0);
	endtask

	task automatic t_restart;
		set_range(28'h000_0020, 28'h000_0023);
		q_addr.delete();
		q_data.delete();
		launch_run;
		wait_words(12);
		bus_op(1'b1, 16'h3009, 32'h0000_0002);
		check_words(28'h000_0020, 12, 2'b01, 4'h2);
	endtask

	task automatic t_halt;
		set_range(28'h000_0100, 28'h000_01ff);
		bus_op(1'b1, 16'h3009, 32'h0000_0001);
		wait_words(4);
		bus_op(1'b1, 16'h3009, 32'h0000_0001);
		q_addr.delete();
		q_data.delete();
		wait_words(2);
		check_val(32'(q_addr[0]), 32'h0000_0100);
		bus_op(1'b1, 16'h3009, 32'h0000_0003);
		q_addr.delete();
		q_data.delete();
		repeat (40) @(posedge sys_clk_in);
		check_val(32'(q_addr.size()), 32'h0000_0000);
		check_busy(1'b0);
	endtask

	task automatic t_trig;
		set_range(28'h000_0040, 28'h000_007f);
		bus_op(1'b1, 16'h3009, 32'h0000_0018);
		pulse(0);
		check_busy(1'b0);
		pulse(1);
		check_busy(1'b1);
		repeat (400) @(posedge sys_clk_in);
		bus_op(1'b1, 16'h3009, 32'h0000_0010);
		pulse(1);
		check_busy(1'b0);
		bus_op(1'b1, 16'h3009, 32'h0000_001c);
		pulse(1);
		check_busy(1'b1);
		repeat (400) @(posedge sys_clk_in);
		pulse(1);
		check_busy(1'b0);
	endtask

	task automatic spi_one(input logic [15:0] a, input logic [31:0] d, input logic [7:0] nb,
		input logic [31:0] exp, input logic [3:0] sel);
		int n;
		bus_op(1'b1, a, d);
		n = 0;
		while (spi_cs_n_out !== 4'hf && n < 300)
		begin
			@(negedge sys_clk_in);
			n++;
		end
		if (n >= 300)
			error_cnt++;
		check_val(32'(spi_nbits), 32'(nb));
		check_val(spi_shift, exp);
		check_val(32'(spi_sel), 32'(sel));
	endtask

	task automatic t_spi;
		for (int s = 0; s < 4; s++)
			spi_one(16'h1800 | 16'(s << 8), 32'hffff_ff80 | 32'(s), 8'h08,
				32'h0000_0080 | 32'(s), ~(4'h1 << s));
		bus_op(1'b1, 16'h1100, 32'h0000_0012);
		repeat (40) @(negedge sys_clk_in);
		check_val(32'(spi_cs_n_out), 32'h0000_000d);
		spi_one(16'h1d34, 32'hffff_ff56, 8'h18, 32'h0012_3456, 4'hd);
	endtask

	task automatic wrap_up;
		if (error_cnt == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		error_cnt = 0;
		n_compared = 0;
		arst_n_in = 1'b0;
		bus_in = '0;
		trig_in = 2'b00;
		repeat (12) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		arst_n_in = 1'b1;
		t_regs;
		t_pins;
		t_capture(8'h02, 2'b10, 4'h1, 1'b0);
		t_capture(8'h31, 2'b01, 4'h2, 1'b1);
		t_restart;
		t_halt;
		t_trig;
		t_spi;
		wrap_up;
	end

	// Whole sequence needs well under a millisecond
	initial
	begin
		#3000000;
		error_cnt++;
		wrap_up;
	end
endmodule
`default_nettype wire
